// >>> hw/selftest_params.svh
/*
 * Constants for the power-up self-test sequencer: register offsets, bit
 * positions, reset values and timing counts.
 * Assumes it is included by bare name from the design files and the test bench.
 */
`ifndef SELFTEST_PARAMS_SVH
`define SELFTEST_PARAMS_SVH

// ****************************************************************
// register offsets
// ****************************************************************
`define ADDR_CTRL 8'h00
`define ADDR_STATUS 8'h04
`define ADDR_FAULT 8'h08
`define ADDR_IRQ_STAT 8'h0C
`define ADDR_IRQ_MASK 8'h10

// ****************************************************************
// control bits (write pulses)
// ****************************************************************
`define CTRL_SETUP_RESET_BIT 0
`define CTRL_EXT_TEST_BIT 1
`define CTRL_GO_ONLINE_BIT 2

// ****************************************************************
// interrupt status and mask layout
// ****************************************************************
`define IRQ_PASS_BIT 0
`define IRQ_NONFATAL_BIT 1
`define IRQ_FATAL_BIT 2
`define IRQ_WIDTH 3
`define IRQ_MASK_RESET 3'h0

// ****************************************************************
// fault character and lamps
// ****************************************************************
`define FAULT_CHAR_BASE 8'h30
`define FAULT_CHAR_RESET 8'h00
`define LAMPS_OFF 4'h0

// ****************************************************************
// timing
// ****************************************************************
`define CLK_MHZ 20
`define CHECK_TIMEOUT_US 10
`define CHECK_TIMEOUT_CYC (`CHECK_TIMEOUT_US * `CLK_MHZ)

`endif

// >>> hw/selftest_pkg.sv
/*
 * Types shared by the self-test sequencer and its fault character encoder.
 * Assumes selftest_params.svh is on the include path.
 */
package selftest_pkg;

	typedef enum logic [3:0] {
		ST_IDLE = 4'b0000,
		ST_INIT = 4'b0001,
		ST_ISSUE = 4'b0010,
		ST_WAIT = 4'b0011,
		ST_REPORT = 4'b0100,
		ST_HALTED = 4'b0101
	} state_t;

	typedef enum logic [2:0] {
		CHK_NONE = 3'b000,
		CHK_ATTR = 3'b001,
		CHK_SETTINGS = 3'b010,
		CHK_KEYBOARD = 3'b011,
		CHK_LOOPBACK = 3'b100,
		CHK_MODEM = 3'b101
	} check_sel_t;

	// bit order gives the weights 16, 8, 4, 2, 1 from top to bottom
	typedef struct packed {
		logic modem_control_fault;
		logic loopback_fault;
		logic keyboard_fault;
		logic settings_store_fault;
		logic attribute_memory_fault;
	} fault_bits_t;

	// one check answer from the checker
	typedef struct packed {
		logic done;
		logic fail;
		logic fatal;
		logic [3:0] fatal_code;
	} check_result_t;

endpackage : selftest_pkg

// >>> hw/fault_char_encoder.sv
/*
 * Turns the set of failed checks into the character shown at screen home.
 * Purely combinational; the caller registers the result.
 */
`timescale 1ns/10ps
`default_nettype none
`include "selftest_params.svh"

module fault_char_encoder
	import selftest_pkg::*;
(
	input wire fault_bits_t i_faults, // failed checks
	output logic [7:0] o_char // displayed character
);

	always_comb begin
		o_char = `FAULT_CHAR_BASE + {3'h0, i_faults};
	end

endmodule : fault_char_encoder
`default_nettype wire

// >>> hw/terminal_selftest_reporter.sv
/*
 * Power-up self-test sequencer and fault reporter with a small register
 * port and one level interrupt.
 * Assumes an external checker that runs one selected check per start pulse
 * and answers with a done pulse; power-good arrives asynchronously.
 */
`timescale 1ns/10ps
`default_nettype none
`include "selftest_params.svh"

// How it works
// - power-on, set-up reset write or host reset each start the power-up sequence, except once halted.
// - every power-up sequence runs settings store and keyboard checks, plus attribute memory when fitted.
// - all checks pass: cursor goes home and the four lamps turn off.
// - fatal fault in a power-up sequence halts everything at once and shows a code on the lamps.
// - nonfatal fault keeps running, forces local mode, shows one fault character.
// - five nonfatal classes: attribute, settings, keyboard, loopback, modem control.
// - loopback and modem tests run only on a separate host request.
// - the fault character identifies the whole set of failed checks.
// - reset first clears graphics memory, then runs the full power-up sequence.
module terminal_selftest_reporter
	import selftest_pkg::*;
#(
	parameter int TIMEOUT_CYC = `CHECK_TIMEOUT_CYC
) (
	input wire logic i_clk, // 20 MHz clock
	input wire logic i_reset, // sync reset, active high
	input wire logic i_power_good, // async power-on level
	input wire logic i_host_reset, // one-cycle host reset sequence seen
	input wire logic i_attr_installed, // attribute memory option fitted
	input wire check_result_t i_check, // checker answer
	input wire logic [7:0] i_addr, // register address
	input wire logic [31:0] i_wdata, // register write data
	input wire logic i_wr, // write strobe
	input wire logic i_rd, // read strobe
	output logic [31:0] o_rdata, // read data, cycle after i_rd
	output logic o_check_start, // start pulse to checker
	output check_sel_t o_check_sel, // check to run
	output logic o_gfx_clear, // clear graphics memories pulse
	output logic o_home_cursor, // cursor home pulse
	output logic [3:0] o_programmable_keyboard_lamps, // lamp code
	output logic o_force_local, // offline local condition
	output logic o_fault_char_valid, // show fault character at home
	output logic [7:0] o_fault_char, // fault character
	output logic o_halted, // fatal halt
	output logic o_irq // interrupt level
);

	// ****************************************************************
	// power-good synchroniser and edge
	// ****************************************************************
	logic pg_s1_r, pg_s2_r, pg_s3_r, pg_lvl_r;
	logic pg_lvl_nxt, pwr_rise;

	always_comb begin
		pg_lvl_nxt = (pg_s2_r == pg_s3_r) ? pg_s3_r : pg_lvl_r;
	end

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			pg_s1_r <= 1'b0;
			pg_s2_r <= 1'b0;
			pg_s3_r <= 1'b0;
			pg_lvl_r <= 1'b0;
		end else begin
			pg_s1_r <= i_power_good;
			pg_s2_r <= pg_s1_r;
			pg_s3_r <= pg_s2_r;
			pg_lvl_r <= pg_lvl_nxt;
		end
	end

	assign pwr_rise = pg_lvl_nxt & ~pg_lvl_r;

	// ****************************************************************
	// sequencing helpers
	// ****************************************************************
	// next check in the current pass; extended tests never chain into power-up ones
	function automatic check_sel_t next_check(input check_sel_t cur);
		case (cur)
			CHK_ATTR: next_check = CHK_SETTINGS;
			CHK_SETTINGS: next_check = CHK_KEYBOARD;
			CHK_LOOPBACK: next_check = CHK_MODEM;
			default: next_check = CHK_NONE;
		endcase
	endfunction : next_check

	function automatic fault_bits_t mark_fault(input fault_bits_t f, input check_sel_t s);
		mark_fault = f;
		case (s)
			CHK_ATTR: mark_fault.attribute_memory_fault = 1'b1;
			CHK_SETTINGS: mark_fault.settings_store_fault = 1'b1;
			CHK_KEYBOARD: mark_fault.keyboard_fault = 1'b1;
			CHK_LOOPBACK: mark_fault.loopback_fault = 1'b1;
			CHK_MODEM: mark_fault.modem_control_fault = 1'b1;
			default: mark_fault = f;
		endcase
	endfunction : mark_fault

	logic ctrl_wr;
	logic setup_reset_wr, ext_test_wr, go_online_wr, trigger;

	assign ctrl_wr = i_wr && (i_addr == `ADDR_CTRL);
	assign setup_reset_wr = ctrl_wr && i_wdata[`CTRL_SETUP_RESET_BIT];
	assign ext_test_wr = ctrl_wr && i_wdata[`CTRL_EXT_TEST_BIT];
	assign go_online_wr = ctrl_wr && i_wdata[`CTRL_GO_ONLINE_BIT];
	assign trigger = pwr_rise | setup_reset_wr | i_host_reset;

	// ****************************************************************
	// sequencer state
	// ****************************************************************
	state_t state_r, state_nxt;
	check_sel_t cur_r, cur_nxt;
	fault_bits_t faults_r, faults_nxt, f_tmp;
	logic ext_r, ext_nxt;
	logic [15:0] timer_r, timer_nxt;
	logic start_nxt, gfx_nxt, home_nxt, local_nxt, cval_nxt;
	logic [3:0] lamps_nxt;
	logic [7:0] char_nxt, enc_char;
	logic ev_pass, ev_nonfatal, ev_fatal;
	logic answered, timed_out;

	fault_char_encoder u_enc (
		.i_faults(faults_r),
		.o_char(enc_char)
	);

	// a missing checker answer counts as a failed check, never a hang
	assign timed_out = (timer_r == 16'(TIMEOUT_CYC - 1));
	assign answered = i_check.done | timed_out;

	always_comb begin
		state_nxt = state_r;
		cur_nxt = cur_r;
		faults_nxt = faults_r;
		ext_nxt = ext_r;
		timer_nxt = timer_r;
		start_nxt = 1'b0;
		gfx_nxt = 1'b0;
		home_nxt = 1'b0;
		local_nxt = o_force_local & ~go_online_wr;
		cval_nxt = o_fault_char_valid;
		lamps_nxt = o_programmable_keyboard_lamps;
		char_nxt = o_fault_char;
		ev_pass = 1'b0;
		ev_nonfatal = 1'b0;
		ev_fatal = 1'b0;
		f_tmp = faults_r;
		if (state_r != ST_HALTED && trigger) begin
			state_nxt = ST_INIT;
			faults_nxt = '0;
			ext_nxt = 1'b0;
			gfx_nxt = 1'b1;
		end else begin
			case (state_r)
				ST_IDLE: begin
					if (ext_test_wr) begin
						ext_nxt = 1'b1;
						faults_nxt.loopback_fault = 1'b0;
						faults_nxt.modem_control_fault = 1'b0;
						cur_nxt = CHK_LOOPBACK;
						state_nxt = ST_ISSUE;
					end
				end
				ST_INIT: begin
					cur_nxt = i_attr_installed ? CHK_ATTR : CHK_SETTINGS;
					state_nxt = ST_ISSUE;
				end
				ST_ISSUE: begin
					start_nxt = 1'b1;
					timer_nxt = '0;
					state_nxt = ST_WAIT;
				end
				ST_WAIT: begin
					timer_nxt = timer_r + 16'h0001;
					if (answered) begin
						if (i_check.done && i_check.fatal && !ext_r) begin
							lamps_nxt = i_check.fatal_code;
							ev_fatal = 1'b1;
							state_nxt = ST_HALTED;
						end else begin
							if (i_check.fail || !i_check.done) begin
								f_tmp = mark_fault(faults_r, cur_r);
							end
							faults_nxt = f_tmp;
							cur_nxt = next_check(cur_r);
							state_nxt = (next_check(cur_r) == CHK_NONE) ? ST_REPORT : ST_ISSUE;
						end
					end
				end
				ST_REPORT: begin
					if (faults_r == '0) begin
						home_nxt = 1'b1;
						lamps_nxt = `LAMPS_OFF;
						cval_nxt = 1'b0;
						ev_pass = 1'b1;
					end else begin
						local_nxt = 1'b1;
						cval_nxt = 1'b1;
						char_nxt = enc_char;
						ev_nonfatal = 1'b1;
					end
					ext_nxt = 1'b0;
					state_nxt = ST_IDLE;
				end
				ST_HALTED: begin
					state_nxt = ST_HALTED;
				end
				default: begin
					state_nxt = ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			state_r <= ST_IDLE;
			cur_r <= CHK_NONE;
			faults_r <= '0;
			ext_r <= 1'b0;
			timer_r <= '0;
			o_check_start <= 1'b0;
			o_gfx_clear <= 1'b0;
			o_home_cursor <= 1'b0;
			o_force_local <= 1'b0;
			o_fault_char_valid <= 1'b0;
			o_programmable_keyboard_lamps <= `LAMPS_OFF;
			o_fault_char <= `FAULT_CHAR_RESET;
			o_halted <= 1'b0;
		end else begin
			state_r <= state_nxt;
			cur_r <= cur_nxt;
			faults_r <= faults_nxt;
			ext_r <= ext_nxt;
			timer_r <= timer_nxt;
			o_check_start <= start_nxt;
			o_gfx_clear <= gfx_nxt;
			o_home_cursor <= home_nxt;
			o_force_local <= local_nxt;
			o_fault_char_valid <= cval_nxt;
			o_programmable_keyboard_lamps <= lamps_nxt;
			o_fault_char <= char_nxt;
			o_halted <= (state_nxt == ST_HALTED);
		end
	end

	assign o_check_sel = cur_r;

	// ****************************************************************
	// register port and interrupt
	// ****************************************************************
	logic [`IRQ_WIDTH-1:0] stat_r, stat_nxt, mask_r, mask_nxt, ev_vec;
	logic [31:0] rdata_nxt;

	always_comb begin
		ev_vec = '0;
		ev_vec[`IRQ_PASS_BIT] = ev_pass;
		ev_vec[`IRQ_NONFATAL_BIT] = ev_nonfatal;
		ev_vec[`IRQ_FATAL_BIT] = ev_fatal;
		stat_nxt = stat_r;
		mask_nxt = mask_r;
		if (i_wr && i_addr == `ADDR_IRQ_STAT) begin
			stat_nxt = stat_r & ~i_wdata[`IRQ_WIDTH-1:0];
		end
		if (i_wr && i_addr == `ADDR_IRQ_MASK) begin
			mask_nxt = i_wdata[`IRQ_WIDTH-1:0];
		end
		// a new event wins over a clear in the same cycle
		stat_nxt = stat_nxt | ev_vec;
		rdata_nxt = '0;
		if (i_rd) begin
			case (i_addr)
				`ADDR_STATUS: rdata_nxt = {20'h0, o_halted, o_force_local, ext_r,
					cur_r, 2'h0, state_r};
				`ADDR_FAULT: rdata_nxt = {11'h0, o_fault_char_valid, o_fault_char,
					3'h0, faults_r, o_programmable_keyboard_lamps};
				`ADDR_IRQ_STAT: rdata_nxt = {29'h0, stat_r};
				`ADDR_IRQ_MASK: rdata_nxt = {29'h0, mask_r};
				default: rdata_nxt = '0;
			endcase
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			stat_r <= '0;
			mask_r <= `IRQ_MASK_RESET;
			o_rdata <= '0;
			o_irq <= 1'b0;
		end else begin
			stat_r <= stat_nxt;
			mask_r <= mask_nxt;
			o_rdata <= rdata_nxt;
			o_irq <= |(stat_nxt & mask_nxt);
		end
	end

	// ****************************************************************
	// assertions
	// ****************************************************************
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_reset);

	sequence s_reset_seen;
		(state_r != ST_HALTED) && trigger;
	endsequence

	sequence s_init_then_issue;
		(state_r == ST_INIT) ##1 (state_r == ST_ISSUE) ##1 o_check_start;
	endsequence

	a_trigger_starts_init: assert property (s_reset_seen |=> o_gfx_clear && state_r == ST_INIT)
		else $error("trigger did not start the power-up sequence");
	a_init_runs_checks: assert property (s_reset_seen |=> s_init_then_issue)
		else $error("init did not lead to the first check");
	a_first_check_sel: assert property ((state_r == ST_INIT && !trigger) |=>
		o_check_sel == ($past(i_attr_installed) ? CHK_ATTR : CHK_SETTINGS))
		else $error("wrong first power-up check");
	a_pass_homes_lamps: assert property ((state_r == ST_REPORT && faults_r == '0 && !trigger) |=>
		o_home_cursor && o_programmable_keyboard_lamps == 4'h0 && !o_fault_char_valid)
		else $error("pass did not home cursor and clear lamps");
	a_fatal_halts: assert property ((state_r == ST_WAIT && i_check.done && i_check.fatal && !ext_r
		&& !trigger) |=> o_halted && o_programmable_keyboard_lamps == $past(i_check.fatal_code)
		##1 o_halted && !o_check_start)
		else $error("fatal fault did not halt with lamp code");
	a_nonfatal_local: assert property ((state_r == ST_REPORT && faults_r != '0 && !trigger) |=>
		o_force_local && o_fault_char_valid && !o_halted)
		else $error("nonfatal fault did not force local mode");
	a_char_weights: assert property ((state_r == ST_REPORT && !trigger && faults_r != '0) |=>
		o_fault_char == 8'h30 + {3'h0, $past(faults_r)})
		else $error("fault character does not match failed checks");
	a_no_ext_powerup: assert property ((o_check_start && !ext_r) |->
		o_check_sel != CHK_LOOPBACK && o_check_sel != CHK_MODEM)
		else $error("loopback or modem test ran during power-up");
	a_fault_bit_kept: assert property ((state_r == ST_WAIT && i_check.done && i_check.fail
		&& !i_check.fatal && cur_r == CHK_KEYBOARD && !trigger) |=> faults_r.keyboard_fault)
		else $error("keyboard fault not recorded");

endmodule : terminal_selftest_reporter
`default_nettype wire

// >>> dv/check_responder.sv
/*
 * Stand-in for the external checker: answers each start pulse with a done pulse i_delay cycles later, unless i_mute is set or i_delay is 0.
 * Assumes the sequencer clock and check_result_t from selftest_pkg.
 */
`timescale 1ns/10ps
`default_nettype none

module check_responder
	import selftest_pkg::*;
(
	input wire logic i_clk, // sequencer clock
	input wire logic i_start, // start pulse
	input wire check_sel_t i_sel, // check to answer
	input wire logic [5:0] i_fail_set, // fail flag per select
	input wire logic [5:0] i_fatal_set, // fatal flag per select
	input wire logic [3:0] i_code, // fatal code
	input wire logic [3:0] i_delay, // cycles from start to done
	input wire logic i_mute, // never answer
	output var check_result_t o_check // answer
);
	int cnt = 0;
	check_sel_t sel_r = CHK_NONE;
	logic junk = 1'b0;
	initial o_check = '0;
	// qualifiers toggle outside done so a stale value is never trusted
	always @(posedge i_clk) begin
		junk <= ~junk;
		o_check <= '{1'b0, junk, junk, {4{junk}}};
		if (i_start) begin
			sel_r <= i_sel;
			cnt <= i_mute ? 0 : int'(i_delay);
		end else if (cnt > 0) begin
			cnt <= cnt - 1;
			if (cnt == 1)
				o_check <= '{1'b1, i_fail_set[sel_r], i_fatal_set[sel_r], i_code};
		end
	end
endmodule : check_responder

`default_nettype wire

// >>> dv/test_terminal_selftest_reporter.sv
/*
 * Self-checking bench for the self-test sequencer.
 * Assumes the design files, selftest_pkg and check_responder are compiled first.
 */
`timescale 1ns/10ps
`default_nettype none
`include "selftest_params.svh"

module test_terminal_selftest_reporter;
	import selftest_pkg::*;
	logic clk;
	logic rst = 1'b1, pg = 1'b1, hrst = 1'b0, attr = 1'b1, wr = 1'b0, rd = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h0000_0000;
	logic [31:0] rdata;
	logic start, gfx, home, loc, cval, halted, irq;
	check_sel_t sel;
	logic [3:0] lamps;
	logic [7:0] fchar;
	check_result_t chk;
	logic [5:0] fail_set = 6'h00, fatal_set = 6'h00;
	logic [3:0] code = 4'h0, dly = 4'h2;
	logic mute = 1'b0;
	int num_errors = 0, cmp_count = 0, n_home = 0, n_gfx = 0;
	logic rd_pend = 1'b0, fin = 1'b0, loc_d = 1'b0, halt_d = 1'b0;
	logic [63:0] expq[$];
	check_sel_t sel_log[$];
	logic [2:0] m;

	terminal_selftest_reporter #(.TIMEOUT_CYC(8)) u_terminal_selftest_reporter (
		.i_clk(clk), .i_reset(rst), .i_power_good(pg), .i_host_reset(hrst),
		.i_attr_installed(attr), .i_check(chk), .i_addr(addr), .i_wdata(wdata),
		.i_wr(wr), .i_rd(rd), .o_rdata(rdata), .o_check_start(start), .o_check_sel(sel),
		.o_gfx_clear(gfx), .o_home_cursor(home), .o_programmable_keyboard_lamps(lamps),
		.o_force_local(loc), .o_fault_char_valid(cval), .o_fault_char(fchar),
		.o_halted(halted), .o_irq(irq));

	check_responder u_check_responder (
		.i_clk(clk), .i_start(start), .i_sel(sel), .i_fail_set(fail_set),
		.i_fatal_set(fatal_set), .i_code(code), .i_delay(dly), .i_mute(mute), .o_check(chk));

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	// ****************************************************************
	// bus tasks and compare
	// ****************************************************************
	task automatic cmp(logic [31:0] got, logic [31:0] exp, string what);
		cmp_count++;
		if (got !== exp) begin
			num_errors++;
			$display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : cmp

	task automatic tick(int n);
		repeat (n) @(posedge clk);
	endtask : tick

	// one idle cycle after each strobe keeps drivers single per step
	task automatic wr_reg(logic [7:0] a, logic [31:0] d);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
		@(posedge clk);
	endtask : wr_reg

	task automatic rd_reg(logic [7:0] a, logic [31:0] e, logic [31:0] msk);
		expq.push_back({msk, e & msk});
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		@(posedge clk);
	endtask : rd_reg

	task automatic wait_fin();
		for (int i = 0; i < 300 && !fin; i++) @(posedge clk);
		cmp(32'(fin), 32'h0000_0001, "sequence end");
		tick(2);
	endtask : wait_fin

	task automatic chk_sel(logic [11:0] e);
		logic [11:0] v;
		v = '0;
		foreach (sel_log[i]) v = {v[7:0], 1'b0, sel_log[i]};
		cmp(32'(v), 32'(e), "check order");
	endtask : chk_sel

	// how: 0 host reset, 1 set-up reset write, 2 extended test
	task automatic run(int how);
		sel_log.delete();
		fin = 1'b0;
		wr_reg(`ADDR_CTRL, 32'h0000_0004);
		if (how == 0) begin
			hrst <= 1'b1;
			@(posedge clk);
			hrst <= 1'b0;
		end else
			wr_reg(`ADDR_CTRL, (how == 1) ? 32'h0000_0001 : 32'h0000_0002);
		wait_fin();
	endtask : run

	task automatic print_verdict();
		$display("errors %0d compares %0d", num_errors, cmp_count);
		if (num_errors == 0 && cmp_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : print_verdict

	// ****************************************************************
	// monitor: pulses, check order and queued reads
	// ****************************************************************
	always @(posedge clk) begin
		rd_pend <= rd;
		loc_d <= loc;
		halt_d <= halted;
		if (home) n_home++;
		if (gfx) n_gfx++;
		if (start) sel_log.push_back(sel);
		if (home || (loc && !loc_d) || (halted && !halt_d)) fin <= 1'b1;
	end

	always @(negedge clk) begin
		logic [63:0] e;
		if (rd_pend) begin
			e = (expq.size() > 0) ? expq.pop_front() : 64'hFFFF_FFFF_DEAD_BEEF;
			cmp(rdata & e[63:32], e[31:0], "read");
		end
	end

	initial begin
		tick(20000);
		num_errors++;
		print_verdict();
	end

	// ****************************************************************
	// tests
	// ****************************************************************
	initial begin
		void'($urandom(32'hcdbc));
		tick(12);
		rst <= 1'b0;
		wait_fin();
		chk_sel(12'h123);
		cmp(32'(n_home), 32'h0000_0001, "home");
		cmp(32'(lamps), 32'h0000_0000, "lamps");
		cmp(32'(n_gfx), 32'h0000_0001, "gfx clear");
		rd_reg(`ADDR_STATUS, 32'h0000_0000, 32'h0000_0C0F);
		$display("test power-on done");
		for (int k = 0; k < 8; k++) begin
			m = (k == 0) ? 3'h7 : 3'($urandom_range(1, 7));
			dly <= 4'($urandom_range(1, 5));
			fail_set <= {2'b00, m, 1'b0};
			run(k % 2);
			chk_sel(12'h123);
			cmp(32'(loc), 32'h0000_0001, "local");
			cmp(32'(fchar), 32'h0000_0030 + 32'(m), "char");
			rd_reg(`ADDR_FAULT, {12'h001, 8'h30 + 8'(m), 3'h0, 2'b00, m, 4'h0}, 32'h001F_FFF0);
		end
		cmp(32'(n_gfx), 32'h0000_0009, "gfx clear");
		mute <= 1'b1;
		run(0);
		cmp(32'(fchar), 32'h0000_0037, "timeout char");
		mute <= 1'b0;
		$display("test nonfatal done");
		for (int j = 1; j < 4; j++) begin
			fail_set <= {2'(j), 4'h0};
			run(2);
			chk_sel(12'h045);
			cmp(32'(fchar), 32'h0000_0037 + 32'(8 * j), "ext char");
		end
		// option not fitted: attribute check must be skipped
		attr <= 1'b0;
		run(1);
		chk_sel(12'h023);
		cmp(32'(cval), 32'h0000_0000, "char cleared");
		cmp(32'(n_home), 32'h0000_0002, "home again");
		attr <= 1'b1;
		$display("test extended done");
		cmp(32'(irq), 32'h0000_0000, "irq masked");
		rd_reg(`ADDR_IRQ_MASK, 32'h0000_0000, 32'hFFFF_FFFF);
		rd_reg(`ADDR_IRQ_STAT, 32'h0000_0003, 32'h0000_0007);
		wr_reg(`ADDR_IRQ_MASK, 32'h0000_0002);
		cmp(32'(irq), 32'h0000_0001, "irq on");
		wr_reg(`ADDR_IRQ_STAT, 32'h0000_0002);
		tick(1);
		cmp(32'(irq), 32'h0000_0000, "irq cleared");
		wr_reg(8'h14, 32'hFFFF_FFFF);
		rd_reg(8'h14, 32'h0000_0000, 32'hFFFF_FFFF);
		rd_reg(`ADDR_CTRL, 32'h0000_0000, 32'hFFFF_FFFF);
		rd_reg(`ADDR_IRQ_STAT, 32'h0000_0001, 32'h0000_0007);
		$display("test registers done");
		fail_set <= 6'h00;
		fatal_set <= 6'h04;
		code <= 4'hA;
		run(0);
		cmp(32'(lamps), 32'h0000_000A, "fatal code");
		hrst <= 1'b1;
		@(posedge clk);
		hrst <= 1'b0;
		tick(20);
		cmp(32'(n_gfx), 32'h0000_000C, "halted restart");
		rd_reg(`ADDR_STATUS, 32'h0000_0800, 32'h0000_0800);
		rd_reg(`ADDR_IRQ_STAT, 32'h0000_0005, 32'h0000_0007);
		rst <= 1'b1;
		tick(4);
		rst <= 1'b0;
		tick(2);
		cmp(32'(halted), 32'h0000_0000, "halt reset");
		$display("test fatal done");
		print_verdict();
	end
endmodule : test_terminal_selftest_reporter

`default_nettype wire
